// [rtl/uhec_pkg.sv]
/*
  Constants and types for the host endpoint control block.
  Assumes an APB master with 32-bit data and byte addresses.
*/
package uhec_pkg;
  // Register byte offsets
  localparam logic [7:0] UHEC_OFF_SEL = 8'h00;
  localparam logic [7:0] UHEC_OFF_FADDR = 8'h04;
  localparam logic [7:0] UHEC_OFF_HUB = 8'h08;
  localparam logic [7:0] UHEC_OFF_CFG = 8'h0c;
  localparam logic [7:0] UHEC_OFF_MAXP = 8'h10;
  localparam logic [7:0] UHEC_OFF_INTV = 8'h14;
  localparam logic [7:0] UHEC_OFF_TOGGLE = 8'h18;
  localparam logic [7:0] UHEC_OFF_STATUS = 8'h1c;
  localparam logic [7:0] UHEC_OFF_ACK = 8'h20;
  localparam logic [7:0] UHEC_OFF_MODE = 8'h24;

  // Field positions
  localparam int UHEC_SEL_DIR_BIT = 8;
  localparam int UHEC_CFG_TGT_LSB = 0;
  localparam int UHEC_CFG_TYPE_LSB = 4;
  localparam int UHEC_CFG_LOW_BIT = 6;
  localparam int UHEC_CFG_AUTO_BIT = 7;
  localparam int UHEC_CFG_SCLR_BIT = 8;
  localparam int UHEC_CFG_DMA_LSB = 9;
  localparam int UHEC_STS_PKT_BIT = 0;
  localparam int UHEC_STS_NAK_BIT = 1;

  localparam int UHEC_MAXP_W = 11;
  localparam int UHEC_CNT_W = 16;

  // Special interval values
  localparam logic [7:0] UHEC_MAX_NAK_LIMIT = 8'h10;
  localparam logic [7:0] UHEC_DISABLE_NAK_LIMIT = 8'h00;

  typedef enum logic [1:0] {
    type_control = 2'h0,
    type_isochronous = 2'h1,
    type_bulk = 2'h2,
    type_interrupt = 2'h3
  } uhec_type_t;

  localparam logic full_rate_select = 1'b0;
  localparam logic low_rate_select = 1'b1;
  localparam logic host_transmit_half = 1'b0;
  localparam logic host_receive_half = 1'b1;

  typedef struct packed {
    logic [6:0] faddr;
    logic [6:0] hub;
    logic [3:0] target_ep;
    uhec_type_t ep_type;
    logic rate;
    logic auto_go;
    logic self_clr;
    logic [1:0] fifo_dma_style;
    logic [UHEC_MAXP_W-1:0] max_payload_size;
    logic [7:0] interval_setting;
  } uhec_ep_cfg_t;

  localparam uhec_ep_cfg_t UHEC_RST_CFG = '0;
endpackage : uhec_pkg

// [rtl/uhec_ctrl.sv]
/*
  Host endpoint control: per endpoint half configuration, NAK timeout
  and polling frame counters, automatic transmit/request/clear, toggles.
  Assumes an APB master, a frame tick per frame and a transaction
  engine that reports NAKs, completions and FIFO levels synchronously.
*/
// Our own choices: the APB interface to the registers and the address map.
// Functional notes
// - Separate readable/writable function address for each endpoint half.
// - Function address of an endpoint is presented with its transactions.
// - Readable hub address kept per endpoint half.
// - Target endpoint number kept per endpoint half.
// - Max payload per half sets auto transmit and request thresholds.
// - Each half selectable full or low speed.
// - Transfer type: control, isochronous, bulk or interrupt.
// - Endpoint zero and bulk use interval as NAK frame limit.
// - NAK timeout raised after 2^(n-1) frames.
// - Interrupt endpoints poll every n frames.
// - Isochronous endpoints poll every 2^(n-1) frames.
// - Maximum interval accepted; disable value never raises NAK timeout.
// - Auto transmit starts once max payload bytes sit in OUT FIFO.
// - Auto request issues next IN once FIFO fits max payload.
// - Auto clear drops packet ready once received data is read.
// - Per endpoint selectable DMA mode for FIFO access.
// - Software acknowledge clears packet ready after data read.
// - Software forces toggle to DATA0 or DATA1.
// - Endpoint zero ignores direction when forcing toggle.
// - Status clear clears exactly the bits set in the mask.
`timescale 1ns/1ps
module uhec_ctrl #(
  parameter int NUM_EP = 4,
  parameter int NI = 2 * NUM_EP,
  parameter int EW = $clog2(NUM_EP),
  parameter int IW = $clog2(NI)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_tick,
  input wire logic [NI-1:0] nak_seen,
  input wire logic [NI-1:0] xact_done,
  input wire logic [NI-1:0] toggle_flip,
  input wire logic [NUM_EP-1:0] rx_pkt_in,
  input wire logic [NUM_EP-1:0] rx_fifo_empty,
  input wire logic [NUM_EP*uhec_pkg::UHEC_MAXP_W-1:0] rx_free,
  input wire logic [NUM_EP*uhec_pkg::UHEC_MAXP_W-1:0] tx_fill,
  input wire logic [IW-1:0] xact_sel,
  output uhec_pkg::uhec_ep_cfg_t xact_cfg,
  output logic xact_toggle,
  output logic [NUM_EP-1:0] tx_start,
  output logic [NUM_EP-1:0] rx_request,
  output logic [NI-1:0] poll_due,
  output logic [NI-1:0] nak_timeout,
  output logic [NUM_EP-1:0] pkt_ready,
  output logic [NI-1:0] toggle,
  output logic host_mode
);
  import uhec_pkg::*;

  localparam int MW = UHEC_MAXP_W;
  localparam int CW = UHEC_CNT_W;

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic map_hit;
  logic [EW-1:0] sel_ep_r;
  logic sel_dir_r;
  logic [IW-1:0] cur;
  logic acc;
  logic wr;
  logic host_r;
  uhec_ep_cfg_t cfg_r [NI];
  uhec_ep_cfg_t xact_cfg_r;
  logic xact_toggle_r;
  logic [NUM_EP-1:0] tx_start_r;
  logic [NUM_EP-1:0] rx_req_r;
  logic [NUM_EP-1:0] pkt_r;
  logic [NI-1:0] poll_r;
  logic [NI-1:0] nakto_r;
  logic [NI-1:0] tog_r;

  assign cur = {sel_ep_r, sel_dir_r};
  // Answer one cycle into the access phase; effects at that same edge
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;

  // One fixed wait state keeps the read mux off the bus path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel & penable & !pready_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
      UHEC_OFF_SEL: begin
        rd_nxt[EW-1:0] = sel_ep_r;
        rd_nxt[UHEC_SEL_DIR_BIT] = sel_dir_r;
      end
      UHEC_OFF_FADDR: rd_nxt[6:0] = cfg_r[cur].faddr;
      UHEC_OFF_HUB: rd_nxt[6:0] = cfg_r[cur].hub;
      UHEC_OFF_CFG: begin
        rd_nxt[UHEC_CFG_TGT_LSB +: 4] = cfg_r[cur].target_ep;
        rd_nxt[UHEC_CFG_TYPE_LSB +: 2] = cfg_r[cur].ep_type;
        rd_nxt[UHEC_CFG_LOW_BIT] = cfg_r[cur].rate;
        rd_nxt[UHEC_CFG_AUTO_BIT] = cfg_r[cur].auto_go;
        rd_nxt[UHEC_CFG_SCLR_BIT] = cfg_r[cur].self_clr;
        rd_nxt[UHEC_CFG_DMA_LSB +: 2] = cfg_r[cur].fifo_dma_style;
      end
      UHEC_OFF_MAXP: rd_nxt[MW-1:0] = cfg_r[cur].max_payload_size;
      UHEC_OFF_INTV: rd_nxt[7:0] = cfg_r[cur].interval_setting;
      UHEC_OFF_TOGGLE: rd_nxt[0] = tog_r[cur];
      UHEC_OFF_STATUS: begin
        rd_nxt[UHEC_STS_PKT_BIT] = sel_dir_r & pkt_r[sel_ep_r];
        rd_nxt[UHEC_STS_NAK_BIT] = nakto_r[cur];
      end
      UHEC_OFF_ACK: rd_nxt = 32'h0000_0000;
      UHEC_OFF_MODE: rd_nxt[0] = host_r;
      default: map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & penable & !pready_r) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
  end

  // Error strobe stands only alongside pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel & penable & !pready_r & !map_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ep_r <= '0;
      sel_dir_r <= host_transmit_half;
    end else if (wr && paddr == UHEC_OFF_SEL) begin
      sel_ep_r <= pwdata[EW-1:0];
      sel_dir_r <= pwdata[UHEC_SEL_DIR_BIT];
    end
  end

  // Host mode gates every strobe toward the engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_r <= 1'b0;
    end else if (wr && paddr == UHEC_OFF_MODE) begin
      host_r <= pwdata[0];
    end
  end

  // Configuration array, one entry per endpoint half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NI; k++) begin
        cfg_r[k] <= UHEC_RST_CFG;
      end
    end else if (wr) begin
      case (paddr)
        UHEC_OFF_FADDR: cfg_r[cur].faddr <= pwdata[6:0];
        UHEC_OFF_HUB: cfg_r[cur].hub <= pwdata[6:0];
        UHEC_OFF_CFG: begin
          cfg_r[cur].target_ep <= pwdata[UHEC_CFG_TGT_LSB +: 4];
          cfg_r[cur].ep_type <=
            uhec_type_t'(pwdata[UHEC_CFG_TYPE_LSB +: 2]);
          cfg_r[cur].rate <= pwdata[UHEC_CFG_LOW_BIT];
          cfg_r[cur].auto_go <= pwdata[UHEC_CFG_AUTO_BIT];
          cfg_r[cur].self_clr <= pwdata[UHEC_CFG_SCLR_BIT];
          cfg_r[cur].fifo_dma_style <=
            pwdata[UHEC_CFG_DMA_LSB +: 2];
        end
        UHEC_OFF_MAXP: cfg_r[cur].max_payload_size <= pwdata[MW-1:0];
        UHEC_OFF_INTV: cfg_r[cur].interval_setting <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Engine view of the half it is about to serve
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xact_cfg_r <= UHEC_RST_CFG;
      xact_toggle_r <= 1'b0;
    end else begin
      xact_cfg_r <= cfg_r[xact_sel];
      xact_toggle_r <= tog_r[xact_sel];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_half
      localparam bit EP0 = (gi < 2);
      uhec_type_t typ;
      logic [7:0] n;
      logic [4:0] n_c;
      logic nak_mode;
      logic [CW-1:0] lim;
      logic [CW-1:0] cnt_r;
      logic nak_act_r;
      logic fire;
      logic hit;
      logic tog_wr;

      assign typ = cfg_r[gi].ep_type;
      assign n = cfg_r[gi].interval_setting;
      // Values past the maximum are held at the maximum
      assign n_c = (n > UHEC_MAX_NAK_LIMIT) ? UHEC_MAX_NAK_LIMIT[4:0]
                                            : n[4:0];
      assign nak_mode = EP0 || typ == type_control
                        || typ == type_bulk;
      always_comb begin
        if (!nak_mode && typ == type_interrupt) begin
          lim = (n == 8'h00) ? CW'(1) : {8'h00, n};
        end else if (n_c == 5'h00) begin
          lim = CW'(1);
        end else begin
          lim = CW'(1) << (n_c - 5'h01);
        end
      end
      assign hit = (cnt_r >= lim - CW'(1));
      assign fire = nak_mode & nak_act_r & frame_tick & hit
                    & (cnt_r != lim)
                    & (n != UHEC_DISABLE_NAK_LIMIT);
      assign tog_wr = wr && paddr == UHEC_OFF_TOGGLE
                      && (EP0 ? sel_ep_r == '0 : cur == IW'(gi));

      // NAK run: a fresh NAK wins over a completion in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          nak_act_r <= 1'b0;
        end else if (nak_seen[gi]) begin
          nak_act_r <= 1'b1;
        end else if (xact_done[gi]) begin
          nak_act_r <= 1'b0;
        end
      end

      // Poll strobe only for periodic halves, gated by host mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          poll_r[gi] <= 1'b0;
        end else begin
          poll_r[gi] <= !nak_mode & frame_tick & hit & host_r;
        end
      end

      // Count parks at the limit so a NAK timeout fires only once
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= '0;
        end else if (nak_mode) begin
          if (!nak_act_r) begin
            cnt_r <= '0;
          end else if (frame_tick && cnt_r != lim) begin
            cnt_r <= cnt_r + CW'(1);
          end
        end else if (frame_tick) begin
          cnt_r <= hit ? '0 : cnt_r + CW'(1);
        end
      end

      // Timeout flag: set wins over a status clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          nakto_r[gi] <= 1'b0;
        end else if (fire) begin
          nakto_r[gi] <= 1'b1;
        end else if (wr && paddr == UHEC_OFF_STATUS && cur == IW'(gi)
                     && pwdata[UHEC_STS_NAK_BIT]) begin
          nakto_r[gi] <= 1'b0;
        end
      end

      // Endpoint zero halves share one toggle, kept in both flops
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tog_r[gi] <= 1'b0;
        end else if (tog_wr) begin
          tog_r[gi] <= pwdata[0];
        end else if (EP0 ? |toggle_flip[1:0] : toggle_flip[gi]) begin
          tog_r[gi] <= !tog_r[gi];
        end
      end
    end

    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      logic [MW-1:0] tx_mp;
      logic [MW-1:0] rx_mp;
      logic tx_full;
      logic rx_room;
      logic tx_full_d_r;
      logic rx_room_d_r;
      logic ack_hit;
      logic sts_hit;

      assign tx_mp = cfg_r[2*gi].max_payload_size;
      assign rx_mp = cfg_r[2*gi+1].max_payload_size;
      assign tx_full = cfg_r[2*gi].auto_go && tx_mp != '0
                       && tx_fill[gi*MW +: MW] >= tx_mp;
      assign rx_room = cfg_r[2*gi+1].auto_go && rx_mp != '0
                       && rx_free[gi*MW +: MW] >= rx_mp
                       && !pkt_r[gi];
      assign ack_hit = wr && paddr == UHEC_OFF_ACK
                       && sel_ep_r == EW'(gi);
      assign sts_hit = wr && paddr == UHEC_OFF_STATUS
                       && sel_ep_r == EW'(gi) && sel_dir_r
                       && pwdata[UHEC_STS_PKT_BIT];

      // Edge only: one start per threshold crossing, not per cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_full_d_r <= 1'b0;
          rx_room_d_r <= 1'b0;
          tx_start_r[gi] <= 1'b0;
          rx_req_r[gi] <= 1'b0;
        end else begin
          tx_full_d_r <= tx_full;
          rx_room_d_r <= rx_room;
          tx_start_r[gi] <= tx_full & !tx_full_d_r & host_r;
          rx_req_r[gi] <= rx_room & !rx_room_d_r & host_r;
        end
      end

      // Packet ready: arrival wins over any clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pkt_r[gi] <= 1'b0;
        end else if (rx_pkt_in[gi]) begin
          pkt_r[gi] <= 1'b1;
        end else if (cfg_r[2*gi+1].self_clr && rx_fifo_empty[gi]) begin
          pkt_r[gi] <= 1'b0;
        end else if (ack_hit || sts_hit) begin
          pkt_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign xact_cfg = xact_cfg_r;
  assign xact_toggle = xact_toggle_r;
  assign tx_start = tx_start_r;
  assign rx_request = rx_req_r;
  assign poll_due = poll_r;
  assign nak_timeout = nakto_r;
  assign pkt_ready = pkt_r;
  assign toggle = tog_r;
  assign host_mode = host_r;
endmodule : uhec_ctrl

// [tb/uhec_eng_model.sv]
/* Transaction engine stand-in: frame ticks and commanded NAKs.
   Assumes the bench raises nak_go for one cycle per NAK. */
`timescale 1ns/1ps
module uhec_eng_model #(
  parameter int FP = 10,
  parameter int NI = 8,
  parameter int IW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nak_go,
  input wire logic [IW-1:0] nak_half,
  output logic frame_tick,
  output logic [NI-1:0] nak_seen
);
  int cnt;
  // Short frames keep the run brief
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      frame_tick <= 1'b0;
    end else begin
      cnt <= (cnt == FP - 1) ? 0 : cnt + 1;
      frame_tick <= (cnt == FP - 1);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nak_seen <= '0;
    else nak_seen <= nak_go ? (NI'(1) << nak_half) : '0;
  end
endmodule : uhec_eng_model

// [tb/uhec_ctrl_sva.sv]
/* Checker on the uhec_ctrl ports, attached by bind from the bench.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module uhec_ctrl_sva #(
  parameter int NUM_EP = 4,
  parameter int NI = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_tick,
  input wire logic [NUM_EP-1:0] tx_start,
  input wire logic [NUM_EP-1:0] rx_request,
  input wire logic [NI-1:0] poll_due,
  input wire logic [NI-1:0] nak_timeout,
  input wire logic [NI-1:0] toggle,
  input wire logic host_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_ready_late: assert property (s_setup ##1 s_wait |=> pready)
    else $error("no answer one cycle into the access");
  a_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_tx_gate: assert property (|tx_start |-> host_mode)
    else $error("transmit start outside host mode");
  a_req_gate: assert property (|rx_request |-> host_mode)
    else $error("request outside host mode");
  a_poll_tick: assert property (|poll_due |-> $past(frame_tick))
    else $error("poll not one cycle after a frame tick");
  a_ep0_toggle: assert property (toggle[0] == toggle[1])
    else $error("endpoint zero toggles differ");
  a_nak_rise: assert property (
    |(nak_timeout & ~$past(nak_timeout)) |-> $past(frame_tick))
    else $error("timeout rose away from a frame tick");
  a_nak_fall: assert property (
    |($past(nak_timeout) & ~nak_timeout) |-> $past(pready) && $past(pwrite))
    else $error("timeout fell without a write");
endmodule : uhec_ctrl_sva

// [tb/usb_host_endpoint_control_tb.sv]
/* Bench for uhec_ctrl: APB tasks and a list of scenarios.
   Assumes the engine stand-in for frame ticks and NAK pulses. */
`timescale 1ns/1ps
module usb_host_endpoint_control_tb;
  import uhec_pkg::*;
  localparam int NUM_EP = 4;
  localparam int NI = 8;
  localparam int FP = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nak_go = 1'b0;
  logic pready, pslverr, frame_tick, xact_toggle, host_mode, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [2:0] nak_half = 3'h2, xact_sel = 3'h0;
  logic [NI-1:0] xact_done = '0, toggle_flip = '0;
  logic [NI-1:0] nak_seen, poll_due, nak_timeout, toggle;
  logic [NUM_EP-1:0] rx_pkt_in = '0, rx_fifo_empty = '0;
  logic [NUM_EP-1:0] tx_start, rx_request, pkt_ready;
  logic [NUM_EP*UHEC_MAXP_W-1:0] rx_free = '0, tx_fill = '0;
  uhec_ep_cfg_t xact_cfg;
  int error_cnt = 0, n_compared = 0, ticks = 0, n, t0;
  initial forever #10 pclk = ~pclk;
  always_ff @(posedge pclk) if (frame_tick) ticks <= ticks + 1;
  uhec_eng_model #(.FP(FP), .NI(NI), .IW(3)) uhec_eng_model_i (.pclk,
    .presetn, .nak_go, .nak_half, .frame_tick, .nak_seen);
  uhec_ctrl #(.NUM_EP(NUM_EP)) uhec_ctrl_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_tick,
    .nak_seen, .xact_done, .toggle_flip, .rx_pkt_in, .rx_fifo_empty,
    .rx_free, .tx_fill, .xact_sel, .xact_cfg, .xact_toggle, .tx_start,
    .rx_request, .poll_due, .nak_timeout, .pkt_ready, .toggle, .host_mode);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic tmo();
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    conclude();
  endtask : tmo
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) tmo();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  function automatic logic sig(input int k, input int i);
    case (k)
      0: return nak_timeout[i];
      1: return poll_due[i];
      2: return tx_start[i];
      3: return rx_request[i];
      default: return frame_tick;
    endcase
  endfunction : sig
  // Cycles until the chosen output is seen high; bound cuts a hang
  task automatic hunt(input int k, input int i, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (sig(k, i) !== 1'b1 && c < 400);
    if (sig(k, i) !== 1'b1) tmo();
  endtask : hunt
  // NAK launched just after a frame tick, so no tick races it
  task automatic nak(output int t);
    @(posedge pclk);
    xact_done <= 8'h04;
    @(posedge pclk);
    xact_done <= 8'h00;
    hunt(4, 0, t);
    @(posedge pclk);
    t = ticks;
    nak_go <= 1'b1;
    @(posedge pclk);
    nak_go <= 1'b0;
  endtask : nak
  task automatic pkt();
    @(posedge pclk);
    rx_pkt_in <= 4'h2;
    @(posedge pclk);
    rx_pkt_in <= 4'h0;
  endtask : pkt
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, UHEC_OFF_MODE, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    bus(1'b1, UHEC_OFF_MODE, 32'h1);
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, UHEC_OFF_SEL, {23'h0, d[0], 8'h01});
      bus(1'b1, UHEC_OFF_FADDR, 32'h21 + d);
      bus(1'b1, UHEC_OFF_HUB, 32'h05 + d);
      bus(1'b1, UHEC_OFF_CFG, d ? 32'h5c2 : 32'h3b1);
      bus(1'b1, UHEC_OFF_MAXP, 32'h40 + d);
    end
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, UHEC_OFF_SEL, {23'h0, d[0], 8'h01});
      bus(1'b0, UHEC_OFF_FADDR, 32'h0);
      chk(rdat, 32'h21 + d);
      bus(1'b0, UHEC_OFF_HUB, 32'h0);
      chk(rdat, 32'h05 + d);
      bus(1'b0, UHEC_OFF_CFG, 32'h0);
      chk(rdat, d ? 32'h5c2 : 32'h3b1);
      bus(1'b0, UHEC_OFF_MAXP, 32'h0);
      chk(rdat, 32'h40 + d);
      xact_sel <= 3'(2 + d);
      repeat (2) @(posedge pclk);
      #1;
      chk({25'h0, xact_cfg.faddr}, 32'h21 + d);
    end
    bus(1'b1, UHEC_OFF_INTV, {24'h0, UHEC_MAX_NAK_LIMIT});
    bus(1'b0, UHEC_OFF_INTV, 32'h0);
    chk(rdat, {24'h0, UHEC_MAX_NAK_LIMIT});
    bus(1'b1, UHEC_OFF_SEL, 32'h0);
    bus(1'b1, UHEC_OFF_TOGGLE, 32'h1);
    #1;
    chk({30'h0, toggle[1:0]}, 32'h3);
    bus(1'b1, UHEC_OFF_SEL, 32'h100);
    bus(1'b1, UHEC_OFF_TOGGLE, 32'h0);
    #1;
    chk({30'h0, toggle[1:0]}, 32'h0);
    @(posedge pclk);
    toggle_flip <= 8'h02;
    @(posedge pclk);
    toggle_flip <= 8'h00;
    #1;
    chk({30'h0, toggle[1:0]}, 32'h3);
    bus(1'b1, UHEC_OFF_SEL, 32'h101);
    bus(1'b1, UHEC_OFF_TOGGLE, 32'h1);
    bus(1'b0, UHEC_OFF_TOGGLE, 32'h0);
    chk({29'h0, rdat[0], toggle[3:2]}, 32'h6);
    chk({31'h0, xact_toggle}, 32'h1);
    bus(1'b1, UHEC_OFF_SEL, 32'h1);
    bus(1'b1, UHEC_OFF_CFG, 32'h20);
    for (int v = 1; v < 4; v++) begin
      bus(1'b1, UHEC_OFF_INTV, 32'(v));
      nak(t0);
      hunt(0, 2, n);
      chk(ticks - t0, 1 << (v - 1));
      bus(1'b0, UHEC_OFF_STATUS, 32'h0);
      chk(rdat, 32'h2);
      bus(1'b1, UHEC_OFF_STATUS, rdat);
      #1;
      chk({31'h0, nak_timeout[2]}, 32'h0);
    end
    bus(1'b1, UHEC_OFF_INTV, {24'h0, UHEC_DISABLE_NAK_LIMIT});
    nak(t0);
    repeat (40 * FP) @(posedge pclk);
    chk({31'h0, nak_timeout[2]}, 32'h0);
    bus(1'b1, UHEC_OFF_SEL, 32'h102);
    bus(1'b1, UHEC_OFF_INTV, 32'h3);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, UHEC_OFF_CFG, k ? 32'h10 : 32'h30);
      hunt(1, 5, n);
      hunt(1, 5, n);
      hunt(1, 5, n);
      chk(n, (k ? 4 : 3) * FP);
    end
    bus(1'b1, UHEC_OFF_SEL, 32'h1);
    bus(1'b1, UHEC_OFF_CFG, 32'ha0);
    bus(1'b1, UHEC_OFF_MAXP, 32'h8);
    tx_fill[11 +: 11] <= 11'h8;
    hunt(2, 1, n);
    chk(n <= 3, 32'h1);
    bus(1'b1, UHEC_OFF_SEL, 32'h101);
    bus(1'b1, UHEC_OFF_CFG, 32'ha0);
    bus(1'b1, UHEC_OFF_MAXP, 32'h8);
    pkt();
    rx_free[11 +: 11] <= 11'h8;
    repeat (6) @(posedge pclk);
    #1;
    chk({31'h0, pkt_ready[1]}, 32'h1);
    bus(1'b1, UHEC_OFF_ACK, 32'h0);
    #1;
    chk({31'h0, pkt_ready[1]}, 32'h0);
    hunt(3, 1, n);
    chk(n <= 3, 32'h1);
    rx_free[11 +: 11] <= 11'h0;
    bus(1'b1, UHEC_OFF_CFG, 32'h1a0);
    pkt();
    rx_fifo_empty <= 4'h2;
    repeat (3) @(posedge pclk);
    #1;
    chk({31'h0, pkt_ready[1]}, 32'h0);
    bus(1'b1, UHEC_OFF_CFG, 32'ha0);
    pkt();
    repeat (3) @(posedge pclk);
    bus(1'b1, UHEC_OFF_STATUS, 32'h2);
    bus(1'b0, UHEC_OFF_STATUS, 32'h0);
    chk(rdat, 32'h1);
    bus(1'b1, UHEC_OFF_STATUS, rdat);
    #1;
    chk({31'h0, pkt_ready[1]}, 32'h0);
    conclude();
  end
endmodule : usb_host_endpoint_control_tb

bind uhec_ctrl uhec_ctrl_sva #(.NUM_EP(NUM_EP), .NI(NI)) uhec_ctrl_sva_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .frame_tick,
  .tx_start, .rx_request, .poll_due, .nak_timeout, .toggle, .host_mode);
